// ==== rtl/cidec_pkg.sv ====
// shared constants and types of the control and indirect-op decoder
package cidec_pkg;

  // ------------------------------------------------------------
  // instruction word
  // ------------------------------------------------------------
  localparam int          WORD_W = 14;

  localparam logic [13:0] PAT_BRANCH_ACC   = 14'h000B;
  localparam logic [13:0] PAT_CALL_ACC     = 14'h000A;
  localparam logic [13:0] PAT_INT_RETURN   = 14'h0009;
  localparam logic [13:0] PAT_PRESCALE_CFG = 14'h0062;
  localparam logic [13:0] PAT_STANDBY      = 14'h0063;
  localparam logic [13:0] PAT_WDOG_CLEAR   = 14'h0064;
  localparam logic [13:0] MASK_PIN_DIR     = 14'h3FF8;
  localparam logic [13:0] PAT_PIN_DIR      = 14'h0060;
  localparam logic [13:0] MASK_RET_LIT     = 14'h3F00;
  localparam logic [13:0] PAT_RET_LIT      = 14'h3400;
  localparam logic [13:0] MASK_PTR_ADD     = 14'h3F80;
  localparam logic [13:0] PAT_PTR_ADD      = 14'h3100;
  localparam logic [13:0] MASK_IND_MOD     = 14'h3FF8;
  localparam logic [13:0] PAT_LOAD_MOD     = 14'h0010;
  localparam logic [13:0] PAT_STORE_MOD    = 14'h0018;
  localparam logic [13:0] MASK_IND_IDX     = 14'h3F80;
  localparam logic [13:0] PAT_LOAD_IDX     = 14'h3F00;
  localparam logic [13:0] PAT_STORE_IDX    = 14'h3F80;

  // field positions
  localparam int MOD_PTR_BIT = 2;
  localparam int IDX_PTR_BIT = 6;
  localparam int IDX_SIGN_BIT = 5;

  // cycle counts
  localparam logic [1:0] CYC_SINGLE   = 2'h1;
  localparam logic [1:0] CYC_PC_LOAD  = 2'h2;
  localparam logic [1:0] CYC_PTR_HIGH = 2'h1;

  // standby flag values
  localparam logic WDOG_EXPIRY_STANDBY = 1'b1;
  localparam logic POWER_DOWN_STANDBY  = 1'b0;

  // ------------------------------------------------------------
  // register map (word index)
  // ------------------------------------------------------------
  localparam int          ADDR_W  = 4;
  localparam int          DATA_W  = 16;
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_IRQCTL  = 4'h1;
  localparam logic [3:0]  OFS_STATUS  = 4'h2;
  localparam logic [3:0]  OFS_COUNT   = 4'h3;
  localparam int          CTRL_EN_BIT = 0;
  localparam int          IRQ_ALLOW_BIT = 7;
  localparam logic        RST_CTRL_EN   = 1'b1;
  localparam logic [7:0]  RST_IRQCTL    = 8'h00;

  typedef enum logic [3:0] {
    OP_OTHER,
    OP_BRANCH_ACC,
    OP_CALL_ACC,
    OP_RET_LIT,
    OP_INT_RETURN,
    OP_PRESCALE_CFG,
    OP_PIN_DIR,
    OP_STANDBY,
    OP_PTR_ADD,
    OP_LOAD_MOD,
    OP_LOAD_IDX,
    OP_STORE_MOD,
    OP_STORE_IDX
  } cidec_op_type;

endpackage

// ==== rtl/cidec_op_if.sv ====
// decoded fields passed between the decoder's own modules
`timescale 1ns/100ps
interface cidec_op_if;
  cidec_pkg::cidec_op_type opClass;
  logic [7:0]              literal;
  logic                    ptrSel;
  logic [1:0]              mode;
  logic [2:0]              portSel;
  logic [1:0]              cycles;
  logic                    pcChange;
  logic                    indirect;

  modport dec (output opClass, literal, ptrSel, mode, portSel);
  modport cyc (input opClass, ptrSel, output cycles, pcChange, indirect);
  modport use_side (input opClass, literal, ptrSel, mode, portSel, cycles,
                    pcChange, indirect);
endinterface

// ==== rtl/cidec_field_decode.sv ====
// classifies a 14-bit word and extracts its operand fields
`timescale 1ns/100ps
module cidec_field_decode (
  input  wire logic [13:0] word,
  cidec_op_if.dec          op
);

  function automatic logic hit(input logic [13:0] w,
                               input logic [13:0] m,
                               input logic [13:0] p);
    hit = (w & m) == p;
  endfunction

  always_comb begin
    op.opClass = cidec_pkg::OP_OTHER;
    op.literal = 8'h00;
    op.ptrSel  = 1'b0;
    op.mode    = 2'h0;
    op.portSel = 3'h0;
    if (word == cidec_pkg::PAT_BRANCH_ACC) begin
      op.opClass = cidec_pkg::OP_BRANCH_ACC;
    end else if (word == cidec_pkg::PAT_CALL_ACC) begin
      op.opClass = cidec_pkg::OP_CALL_ACC;
    end else if (word == cidec_pkg::PAT_INT_RETURN) begin
      op.opClass = cidec_pkg::OP_INT_RETURN;
    end else if (word == cidec_pkg::PAT_PRESCALE_CFG) begin
      op.opClass = cidec_pkg::OP_PRESCALE_CFG;
    end else if (word == cidec_pkg::PAT_STANDBY) begin
      op.opClass = cidec_pkg::OP_STANDBY;
    end else if (word == cidec_pkg::PAT_WDOG_CLEAR) begin
      op.opClass = cidec_pkg::OP_OTHER;
    end else if (hit(word, cidec_pkg::MASK_PIN_DIR,
                     cidec_pkg::PAT_PIN_DIR)) begin
      op.opClass = cidec_pkg::OP_PIN_DIR;
      op.portSel = word[2:0];
    end else if (hit(word, cidec_pkg::MASK_RET_LIT,
                     cidec_pkg::PAT_RET_LIT)) begin
      op.opClass = cidec_pkg::OP_RET_LIT;
      op.literal = word[7:0];
    end else if (hit(word, cidec_pkg::MASK_PTR_ADD,
                     cidec_pkg::PAT_PTR_ADD)) begin
      op.opClass = cidec_pkg::OP_PTR_ADD;
      op.ptrSel  = word[cidec_pkg::IDX_PTR_BIT];
      op.literal = {2'h0, word[5:0]};
    end else if (hit(word, cidec_pkg::MASK_IND_MOD,
                     cidec_pkg::PAT_LOAD_MOD) ||
                 hit(word, cidec_pkg::MASK_IND_MOD,
                     cidec_pkg::PAT_STORE_MOD)) begin
      op.opClass = word[3] ? cidec_pkg::OP_STORE_MOD
                           : cidec_pkg::OP_LOAD_MOD;
      op.ptrSel  = word[cidec_pkg::MOD_PTR_BIT];
      op.mode    = word[1:0];
    end else if (hit(word, cidec_pkg::MASK_IND_IDX,
                     cidec_pkg::PAT_LOAD_IDX) ||
                 hit(word, cidec_pkg::MASK_IND_IDX,
                     cidec_pkg::PAT_STORE_IDX)) begin
      op.opClass = word[7] ? cidec_pkg::OP_STORE_IDX
                           : cidec_pkg::OP_LOAD_IDX;
      op.ptrSel  = word[cidec_pkg::IDX_PTR_BIT];
      op.literal = {{2{word[cidec_pkg::IDX_SIGN_BIT]}}, word[5:0]};
    end
  end

endmodule // cidec_field_decode

// ==== rtl/cidec_cycle_ctrl.sv ====
// works out the cycle count of a decoded word
`timescale 1ns/100ps
module cidec_cycle_ctrl (
  input  wire logic [1:0] ptrMsb,
  cidec_op_if.cyc         op
);

  always_comb begin
    op.pcChange = op.opClass inside {cidec_pkg::OP_BRANCH_ACC,
                                     cidec_pkg::OP_CALL_ACC,
                                     cidec_pkg::OP_RET_LIT,
                                     cidec_pkg::OP_INT_RETURN};
    op.indirect = op.opClass inside {cidec_pkg::OP_LOAD_MOD,
                                     cidec_pkg::OP_LOAD_IDX,
                                     cidec_pkg::OP_STORE_MOD,
                                     cidec_pkg::OP_STORE_IDX};
    // program counter loads take a trailing no-operation cycle
    op.cycles = op.pcChange ? cidec_pkg::CYC_PC_LOAD
                            : cidec_pkg::CYC_SINGLE;
    // high half of the pointer space costs one more cycle
    if (op.indirect && ptrMsb[op.ptrSel]) begin
      op.cycles = 2'(op.cycles + cidec_pkg::CYC_PTR_HIGH);
    end
  end

endmodule // cidec_cycle_ctrl

// ==== rtl/cidec_decoder.sv ====
// top of the control and indirect-op instruction decoder
`timescale 1ns/100ps
module cidec_decoder (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // instruction fetch
  input  wire logic                          instrValid,
  input  wire logic [cidec_pkg::WORD_W-1:0]  instrWord,
  output logic                               fetchReady,
  // pointer top bits from the execution stage
  input  wire logic [1:0]                    ptrMsb,
  // decoded controls
  output logic                               opValid,
  output cidec_pkg::cidec_op_type            opClass,
  output logic [7:0]                         opLiteral,
  output logic                               opPtrSel,
  output logic [1:0]                         opMode,
  output logic [2:0]                         opPortSel,
  output logic [1:0]                         opCycles,
  output logic                               nopCycle,
  output logic                               pcLoad,
  output logic                               stackPop,
  output logic                               stackPush,
  output logic                               accWrite,
  output logic                               zeroFlagUpd,
  output logic                               standbyFlagUpd,
  output logic                               wdogExpiryVal,
  output logic                               powerDownVal,
  output logic                               globalIrqAllow,
  // register port
  input  wire logic [cidec_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [cidec_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic [cidec_pkg::DATA_W-1:0]       regRdata
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic                    ready;
    logic [1:0]              remain;
    logic                    opValid;
    cidec_pkg::cidec_op_type opClass;
    cidec_pkg::cidec_op_type lastClass;
    logic [7:0]              literal;
    logic                    ptrSel;
    logic [1:0]              mode;
    logic [2:0]              portSel;
    logic [1:0]              cycles;
    logic                    nop;
    logic                    pcLoad;
    logic                    stackPop;
    logic                    stackPush;
    logic                    accWrite;
    logic                    zeroUpd;
    logic                    standbyUpd;
    logic                    wdogExpiry;
    logic                    powerDown;
    logic                    decodeEn;
    logic [7:0]              irqCtl;
    logic [15:0]             count;
    logic [15:0]             rdata;
  } cidec_state_type;

  cidec_state_type state_reg;
  cidec_state_type state_next;

  // ------------------------------------------------------------
  // field decode and cycle count
  // ------------------------------------------------------------
  cidec_op_if op ();

  cidec_field_decode u_field (
    .word (instrWord),
    .op   (op.dec)
  );

  cidec_cycle_ctrl u_cycle (
    .ptrMsb (ptrMsb),
    .op     (op.cyc)
  );

  // ------------------------------------------------------------
  // register readback
  // ------------------------------------------------------------
  function automatic logic [15:0] read_word(input cidec_state_type s,
                                            input logic [3:0] a);
    read_word = 16'h0000;
    unique case (a)
      cidec_pkg::OFS_CTRL:   read_word = {15'h0000, s.decodeEn};
      cidec_pkg::OFS_IRQCTL: read_word = {8'h00, s.irqCtl};
      cidec_pkg::OFS_STATUS: read_word = {8'h00, s.lastClass, s.remain,
                                          s.nop, s.ready};
      cidec_pkg::OFS_COUNT:  read_word = s.count;
      default:               read_word = 16'h0000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic take;
  logic setIrqAllow;

  always_comb begin
    state_next = state_reg;
    take = state_reg.ready && instrValid && state_reg.decodeEn;
    setIrqAllow = 1'b0;

    // per-cycle pulses default low
    state_next.opValid    = 1'b0;
    state_next.nop        = 1'b0;
    state_next.pcLoad     = 1'b0;
    state_next.stackPop   = 1'b0;
    state_next.stackPush  = 1'b0;
    state_next.accWrite   = 1'b0;
    state_next.zeroUpd    = 1'b0;
    state_next.standbyUpd = 1'b0;

    if (take) begin
      // one class per word, all controls issued together
      state_next.opValid   = 1'b1;
      state_next.opClass   = op.opClass;
      state_next.lastClass = op.opClass;
      state_next.literal   = op.literal;
      state_next.ptrSel    = op.ptrSel;
      state_next.mode      = op.mode;
      state_next.portSel   = op.portSel;
      state_next.cycles    = op.cycles;
      state_next.remain    = 2'(op.cycles - 2'h1);
      state_next.ready     = op.cycles == cidec_pkg::CYC_SINGLE;
      state_next.pcLoad    = op.pcChange;
      state_next.count     = 16'(state_reg.count + 16'h0001);
      unique case (op.opClass)
        cidec_pkg::OP_BRANCH_ACC: begin
        end
        cidec_pkg::OP_CALL_ACC: begin
          state_next.stackPush = 1'b1;
        end
        cidec_pkg::OP_RET_LIT: begin
          state_next.stackPop = 1'b1;
          state_next.accWrite = 1'b1;
        end
        cidec_pkg::OP_INT_RETURN: begin
          state_next.stackPop = 1'b1;
          setIrqAllow = 1'b1;
        end
        cidec_pkg::OP_STANDBY: begin
          state_next.standbyUpd = 1'b1;
          state_next.wdogExpiry = cidec_pkg::WDOG_EXPIRY_STANDBY;
          state_next.powerDown  = cidec_pkg::POWER_DOWN_STANDBY;
        end
        cidec_pkg::OP_LOAD_MOD, cidec_pkg::OP_LOAD_IDX: begin
          state_next.accWrite = 1'b1; // and
          state_next.zeroUpd  = 1'b1;
        end
        default: begin
          // remaining classes leave flags alone
        end
      endcase
    end else if (state_reg.remain != 2'h0) begin
      // trailing cycles execute as no-operation
      state_next.nop    = 1'b1; // and
      state_next.remain = 2'(state_reg.remain - 2'h1);
      state_next.ready  = state_reg.remain == 2'h1;
    end

    // software registers
    if (regWr && regAddr == cidec_pkg::OFS_CTRL) begin
      state_next.decodeEn = regWdata[cidec_pkg::CTRL_EN_BIT];
    end
    if (regWr && regAddr == cidec_pkg::OFS_IRQCTL) begin
      state_next.irqCtl = regWdata[7:0];
    end
    // hardware set wins over a software clear in the same cycle
    if (setIrqAllow) begin
      state_next.irqCtl[cidec_pkg::IRQ_ALLOW_BIT] = 1'b1;
    end

    state_next.rdata = regRd ? read_word(state_reg, regAddr) : 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg            <= '0;
      state_reg.ready      <= 1'b1;
      state_reg.opClass    <= cidec_pkg::OP_OTHER;
      state_reg.lastClass  <= cidec_pkg::OP_OTHER;
      state_reg.cycles     <= cidec_pkg::CYC_SINGLE;
      state_reg.wdogExpiry <= 1'b1;
      state_reg.powerDown  <= 1'b1;
      state_reg.decodeEn   <= cidec_pkg::RST_CTRL_EN;
      state_reg.irqCtl     <= cidec_pkg::RST_IRQCTL;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign fetchReady     = state_reg.ready;
  assign opValid        = state_reg.opValid;
  assign opClass        = state_reg.opClass;
  assign opLiteral      = state_reg.literal;
  assign opPtrSel       = state_reg.ptrSel;
  assign opMode         = state_reg.mode;
  assign opPortSel      = state_reg.portSel;
  assign opCycles       = state_reg.cycles;
  assign nopCycle       = state_reg.nop;
  assign pcLoad         = state_reg.pcLoad;
  assign stackPop       = state_reg.stackPop;
  assign stackPush      = state_reg.stackPush;
  assign accWrite       = state_reg.accWrite;
  assign zeroFlagUpd    = state_reg.zeroUpd;
  assign standbyFlagUpd = state_reg.standbyUpd;
  assign wdogExpiryVal  = state_reg.wdogExpiry;
  assign powerDownVal   = state_reg.powerDown;
  assign globalIrqAllow = state_reg.irqCtl[cidec_pkg::IRQ_ALLOW_BIT];
  assign regRdata       = state_reg.rdata;

endmodule // cidec_decoder

// ==== verif/cidec_prog_mem.sv ====
// program memory model offering instruction words to the decoder
`timescale 1ns/100ps
module cidec_prog_mem (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        fetchReady,
  input  wire logic        acceptEn,
  input  wire logic        stall,
  output logic             instrValid,
  output logic [13:0]      instrWord
);
  logic [13:0] wordQ [$];
  logic [13:0] lastWord;

  initial begin
    instrValid = 1'b0;
    instrWord  = 14'h0000;
    lastWord   = 14'h0000;
  end

  task automatic push(input logic [13:0] w);
    wordQ.push_back(w);
  endtask

  // the front word is offered whenever stall is low, until it is popped with fetchReady and acceptEn high
  always @(posedge sys_clk) begin
    if (rst) begin
      wordQ.delete();
      instrValid <= 1'b0;
    end else begin
      if (instrValid && fetchReady && acceptEn) begin
        lastWord = wordQ.pop_front();
      end
      if (wordQ.size() > 0 && !stall) begin
        instrValid <= 1'b1;
        instrWord  <= wordQ[0];
      end else begin
        instrValid <= 1'b0;
        // idle bus never repeats the last word
        instrWord  <= ~lastWord;
      end
    end
  end
endmodule // cidec_prog_mem

// ==== verif/cidec_decoder_monitor.sv ====
// concurrent checks on the decoder's top-level ports
`timescale 1ns/100ps
module cidec_decoder_monitor (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic                    instrValid,
  input wire logic [13:0]             instrWord,
  input wire logic                    fetchReady,
  input wire logic [1:0]              ptrMsb,
  input wire logic                    opValid,
  input wire cidec_pkg::cidec_op_type opClass,
  input wire logic [7:0]              opLiteral,
  input wire logic                    opPtrSel,
  input wire logic [2:0]              opPortSel,
  input wire logic [1:0]              opCycles,
  input wire logic                    nopCycle,
  input wire logic                    pcLoad,
  input wire logic                    stackPop,
  input wire logic                    stackPush,
  input wire logic                    accWrite,
  input wire logic                    zeroFlagUpd,
  input wire logic                    standbyFlagUpd,
  input wire logic                    wdogExpiryVal,
  input wire logic                    powerDownVal,
  input wire logic                    globalIrqAllow
);
  default clocking mcb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_branch_two_cycles: assert property (
    opValid && opClass == cidec_pkg::OP_BRANCH_ACC |->
    pcLoad && !fetchReady && opCycles == 2'h2 ##1 nopCycle && fetchReady)
    else $error("branch did not take two cycles");
  a_call_pushes: assert property (
    opValid && opClass == cidec_pkg::OP_CALL_ACC |->
    stackPush && pcLoad && opCycles == 2'h2 ##1 nopCycle)
    else $error("call controls wrong");
  a_retlit_literal: assert property (
    opValid && opClass == cidec_pkg::OP_RET_LIT |-> stackPop && accWrite
    && opLiteral == $past(instrWord[7:0]) && opCycles == 2'h2)
    else $error("return literal wrong");
  a_prescale_single: assert property (
    opValid && opClass == cidec_pkg::OP_PRESCALE_CFG |-> opCycles == 2'h1
    && fetchReady && !zeroFlagUpd && !standbyFlagUpd)
    else $error("prescale load wrong");
  a_pindir_port: assert property (
    opValid && opClass == cidec_pkg::OP_PIN_DIR |->
    opPortSel == $past(instrWord[2:0]) && opCycles == 2'h1)
    else $error("pin direction port wrong");
  a_standby_flags: assert property (
    opValid && opClass == cidec_pkg::OP_STANDBY |-> standbyFlagUpd
    && wdogExpiryVal && !powerDownVal && opCycles == 2'h1)
    else $error("standby flags wrong");
  a_ptradd_literal: assert property (
    opValid && opClass == cidec_pkg::OP_PTR_ADD |-> !zeroFlagUpd
    && opLiteral == {2'h0, $past(instrWord[5:0])}
    && opPtrSel == $past(instrWord[6]))
    else $error("pointer add fields wrong");
  a_load_zero: assert property (
    opValid && opClass inside {cidec_pkg::OP_LOAD_MOD,
    cidec_pkg::OP_LOAD_IDX} |-> zeroFlagUpd && accWrite)
    else $error("indirect load flags wrong");
  a_store_noflag: assert property (
    opValid && opClass inside {cidec_pkg::OP_STORE_MOD,
    cidec_pkg::OP_STORE_IDX} |-> !zeroFlagUpd && !accWrite)
    else $error("indirect store touched flags");
  a_ptr_extra: assert property (
    opValid && opClass inside {cidec_pkg::OP_LOAD_MOD,
    cidec_pkg::OP_LOAD_IDX, cidec_pkg::OP_STORE_MOD,
    cidec_pkg::OP_STORE_IDX} && (opPtrSel ? $past(ptrMsb[1])
    : $past(ptrMsb[0])) |-> opCycles == 2'h2 && !fetchReady ##1 nopCycle)
    else $error("pointer extra cycle missing");
  a_intret_allow: assert property (
    opValid && opClass == cidec_pkg::OP_INT_RETURN |->
    globalIrqAllow && stackPop && pcLoad)
    else $error("interrupt return wrong");
  a_valid_after_take: assert property (
    opValid |-> $past(instrValid && fetchReady))
    else $error("decode without a take");
endmodule // cidec_decoder_monitor

// ==== verif/cidec_decoder_tb.sv ====
// self-checking bench of the control and indirect-op decoder
`timescale 1ns/100ps
module cidec_decoder_tb;
  typedef struct packed {
    logic [13:0]             w;
    logic [1:0]              msb;
    cidec_pkg::cidec_op_type cls;
    logic [7:0]              lit;
    logic [1:0]              cyc;
    logic [5:0]              pul;
    logic [5:0]              fld;
    logic [5:0]              fm;
  } cidec_row_type;

  logic sys_clk, rst, regWr, regRd, acceptEn, stall, instrValid, fetchReady;
  logic opValid, opPtrSel, nopCycle, pcLoad, stackPop, stackPush, accWrite;
  logic zeroFlagUpd, standbyFlagUpd, wdogExpiryVal, powerDownVal;
  logic globalIrqAllow;
  logic [13:0] instrWord;
  logic [1:0]  ptrMsb, opMode, opCycles;
  logic [2:0]  opPortSel;
  logic [7:0]  opLiteral;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata;
  cidec_pkg::cidec_op_type opClass;
  cidec_row_type rows [15];
  cidec_row_type r;
  int i, k, num_errors, n_compared;

  cidec_decoder i_cidec_decoder (.sys_clk(sys_clk), .rst(rst),
    .instrValid(instrValid), .instrWord(instrWord),
    .fetchReady(fetchReady), .ptrMsb(ptrMsb), .opValid(opValid),
    .opClass(opClass), .opLiteral(opLiteral), .opPtrSel(opPtrSel),
    .opMode(opMode), .opPortSel(opPortSel), .opCycles(opCycles),
    .nopCycle(nopCycle), .pcLoad(pcLoad), .stackPop(stackPop),
    .stackPush(stackPush), .accWrite(accWrite), .zeroFlagUpd(zeroFlagUpd),
    .standbyFlagUpd(standbyFlagUpd), .wdogExpiryVal(wdogExpiryVal),
    .powerDownVal(powerDownVal), .globalIrqAllow(globalIrqAllow),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  cidec_prog_mem i_cidec_prog_mem (.sys_clk(sys_clk), .rst(rst),
    .fetchReady(fetchReady), .acceptEn(acceptEn), .stall(stall),
    .instrValid(instrValid), .instrWord(instrWord));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_op();
    tick();
    for (int n = 0; n < 20 && opValid !== 1'b1; n++) tick();
    cmp({15'h0, opValid}, 16'h0001);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1;
    cmp(regRdata, exp);
  endtask
  task automatic finish_test();
    $display("num_errors=%0d n_compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #40000;
    num_errors++;
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, regAddr, regWdata, regWr, regRd} = {1'b1, 4'h0, 16'h0, 2'h0};
    {ptrMsb, stall, acceptEn} = {2'h0, 1'b0, 1'b1};
    rows[0] = '{14'h000B, 2'h0, cidec_pkg::OP_BRANCH_ACC, 8'h00,
                2'h2, 6'h20, 6'h00, 6'h00};
    rows[1] = '{14'h000A, 2'h0, cidec_pkg::OP_CALL_ACC, 8'h00,
                2'h2, 6'h28, 6'h00, 6'h00};
    rows[2] = '{14'h34A5, 2'h0, cidec_pkg::OP_RET_LIT, 8'hA5,
                2'h2, 6'h34, 6'h00, 6'h00};
    rows[3] = '{14'h0009, 2'h0, cidec_pkg::OP_INT_RETURN, 8'h00,
                2'h2, 6'h30, 6'h00, 6'h00};
    rows[4] = '{14'h0062, 2'h0, cidec_pkg::OP_PRESCALE_CFG, 8'h00,
                2'h1, 6'h00, 6'h00, 6'h00};
    rows[5] = '{14'h0060, 2'h0, cidec_pkg::OP_PIN_DIR, 8'h00,
                2'h1, 6'h00, 6'h00, 6'h07};
    rows[6] = '{14'h0067, 2'h0, cidec_pkg::OP_PIN_DIR, 8'h00,
                2'h1, 6'h00, 6'h07, 6'h07};
    rows[7] = '{14'h0063, 2'h0, cidec_pkg::OP_STANDBY, 8'h00,
                2'h1, 6'h01, 6'h00, 6'h00};
    rows[8] = '{14'h317F, 2'h0, cidec_pkg::OP_PTR_ADD, 8'h3F,
                2'h1, 6'h00, 6'h20, 6'h20};
    rows[9] = '{14'h0012, 2'h2, cidec_pkg::OP_LOAD_MOD, 8'h00,
                2'h1, 6'h06, 6'h10, 6'h38};
    rows[10] = '{14'h0016, 2'h2, cidec_pkg::OP_LOAD_MOD, 8'h00,
                 2'h2, 6'h06, 6'h30, 6'h38};
    rows[11] = '{14'h3F20, 2'h0, cidec_pkg::OP_LOAD_IDX, 8'hE0,
                 2'h1, 6'h06, 6'h00, 6'h20};
    rows[12] = '{14'h3FBF, 2'h1, cidec_pkg::OP_STORE_IDX, 8'hFF,
                 2'h2, 6'h00, 6'h00, 6'h20};
    rows[13] = '{14'h001D, 2'h0, cidec_pkg::OP_STORE_MOD, 8'h00,
                 2'h1, 6'h00, 6'h28, 6'h38};
    rows[14] = '{14'h0064, 2'h0, cidec_pkg::OP_OTHER, 8'h00,
                 2'h1, 6'h00, 6'h00, 6'h00};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    tick();
    cmp({14'h0, wdogExpiryVal, powerDownVal}, 16'h0003);
    reg_rd(cidec_pkg::OFS_CTRL, 16'h0001);
    reg_rd(cidec_pkg::OFS_IRQCTL, 16'h0000);
    for (i = 0; i < 15; i++) begin
      r = rows[i];
      @(posedge sys_clk);
      ptrMsb <= r.msb;
      #1;
      i_cidec_prog_mem.push(r.w);
      wait_op();
      cmp({12'h0, opClass}, {12'h0, r.cls});
      cmp({8'h0, opLiteral}, {8'h0, r.lit});
      cmp({14'h0, opCycles}, {14'h0, r.cyc});
      cmp({10'h0, pcLoad, stackPop, stackPush, accWrite, zeroFlagUpd,
           standbyFlagUpd}, {10'h0, r.pul});
      cmp({10'h0, {opPtrSel, opMode, opPortSel} & r.fm},
          {10'h0, r.fld});
      for (k = 1; k < r.cyc; k++) begin
        tick();
        cmp({14'h0, nopCycle, fetchReady}, 16'h0003);
      end
    end
    cmp({14'h0, wdogExpiryVal, powerDownVal}, 16'h0002);
    cmp({15'h0, globalIrqAllow}, 16'h0001);
    reg_rd(cidec_pkg::OFS_IRQCTL, 16'h0080);
    reg_rd(cidec_pkg::OFS_COUNT, 16'h000F);
    reg_rd(cidec_pkg::OFS_STATUS, 16'h0001);
    reg_wr(4'hF, 16'hFFFF);
    reg_rd(4'hF, 16'h0000);
    reg_wr(cidec_pkg::OFS_IRQCTL, 16'h0000);
    tick();
    cmp({15'h0, globalIrqAllow}, 16'h0000);
    // back-to-back single-cycle words
    i_cidec_prog_mem.push(14'h0062);
    i_cidec_prog_mem.push(14'h0065);
    wait_op();
    cmp({12'h0, opClass}, {12'h0, cidec_pkg::OP_PRESCALE_CFG});
    tick();
    cmp({15'h0, opValid}, 16'h0001);
    cmp({13'h0, opPortSel}, 16'h0005);
    // decode disabled: the word waits
    reg_wr(cidec_pkg::OFS_CTRL, 16'h0000);
    acceptEn <= 1'b0;
    i_cidec_prog_mem.push(14'h000B);
    repeat (4) begin
      tick();
      cmp({15'h0, opValid}, 16'h0000);
    end
    @(posedge sys_clk);
    stall <= 1'b1;
    @(posedge sys_clk);
    acceptEn <= 1'b1;
    reg_wr(cidec_pkg::OFS_CTRL, 16'h0001);
    stall <= 1'b0;
    wait_op();
    cmp({12'h0, opClass}, {12'h0, cidec_pkg::OP_BRANCH_ACC});
    // reset in the trailing cycle of a branch
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    tick();
    cmp({12'h0, fetchReady, nopCycle, opCycles}, 16'h0009);
    cmp({14'h0, wdogExpiryVal, powerDownVal}, 16'h0003);
    reg_rd(cidec_pkg::OFS_CTRL, 16'h0001);
    finish_test();
  end
endmodule // cidec_decoder_tb

bind cidec_decoder cidec_decoder_monitor i_cidec_decoder_monitor (
  .sys_clk, .rst, .instrValid, .instrWord, .fetchReady, .ptrMsb, .opValid,
  .opClass, .opLiteral, .opPtrSel, .opPortSel, .opCycles, .nopCycle,
  .pcLoad, .stackPop, .stackPush, .accWrite, .zeroFlagUpd, .standbyFlagUpd,
  .wdogExpiryVal, .powerDownVal, .globalIrqAllow);
